// [verilog/b4s_pkg.sv]
// Constants shared by the burst-of-four SRAM command port and its buffer.
// Assumes one system clock whose consecutive edges stand for the K and K#
// rising edges in turn; the K slot is tracked inside the command port.
// Function
// - Burst addresses are start, then start+1, +2 and +3, made inside.
// - Strobe low and select high at a K edge starts a read burst.
// - Strobe low and select low at a K edge starts a write burst.
// - A new start address is taken only at K edges with strobe low.
// - Strobe high at a K edge: no operation, select ignored, bus released.
// - Bursts end before the clocks halt; halted data pins hold their state.
// - Read beats appear at K t+2.0, then alternate edges through t+3.5.
// - Two active-low lane enables per beat gate bits 0-8 and 9-17.
// - Reads of the last two written bursts return buffered data.
package b4s_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 18;
    localparam int LANE_N = 2;
    localparam int LANE_BITS = 9;
    localparam int BEATS = 4;
    // Stages count system edges (half K cycles) since the command edge
    localparam int RD_FIRST_STAGE = 4;
    localparam int RD_LAST_STAGE = 7;
    localparam int WR_FIRST_STAGE = 2;
    localparam int WR_LAST_STAGE = 5;
    localparam int PIPE_STAGES = 7;
    localparam int HIST_N = 2;
    localparam int WBUF_DEPTH = 32;
    localparam int WBUF_W = ADDR_W + DATA_W + LANE_N;
    localparam int MEM_WORDS = 1 << ADDR_W;
    localparam logic K_SLOT_RST = 1'b1;
    localparam logic [DATA_W-1:0] DQ_OUT_RST = 18'h00000;
    localparam logic [LANE_N-1:0] LANES_NONE = 2'h0;
endpackage

// [verilog/b4s_wbuf_fifo.sv]
// Write buffer FIFO between bus capture and the array port.
// Assumes a single clock, synchronous active-low reset, power-of-two depth.
`timescale 1ns/1ps
module b4s_wbuf_fifo #(
    parameter int W = 40,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem[rd_ptr_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// [verilog/b4s_command_port.sv]
// Memory-side command, burst and data-phase logic of a four-beat DDR SRAM.
// Assumes SYS_CLK edges alternate between K and K# rising edges; K_SLOT
// high means the coming edge is a K edge. Inputs are synchronous.
`timescale 1ns/1ps
module b4s_command_port (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic LOAD_STROBE_N,
    input wire logic RW_SEL,
    input wire logic [b4s_pkg::ADDR_W-1:0] ADDR,
    input wire logic BYTE_LANE0_WRITE_N,
    input wire logic BYTE_LANE1_WRITE_N,
    input wire logic [b4s_pkg::DATA_W-1:0] DQ_IN,
    output logic [b4s_pkg::DATA_W-1:0] DQ_OUT,
    output logic DQ_OE,
    output logic K_SLOT,
    output logic WBUF_FULL,
    output logic WBUF_OVERRUN
);
    localparam int AW = b4s_pkg::ADDR_W;
    localparam int DW = b4s_pkg::DATA_W;
    localparam int LN = b4s_pkg::LANE_N;
    localparam int LB = b4s_pkg::LANE_BITS;
    localparam int NS = b4s_pkg::PIPE_STAGES;
    localparam int HN = b4s_pkg::HIST_N;
    localparam int BN = b4s_pkg::BEATS;
    localparam int FW = b4s_pkg::WBUF_W;

    // Oldest valid stage in [lo, hi]; 0 when none
    function automatic logic [2:0] stage_pick(input logic [NS:0] v,
                                              input int lo, input int hi);
        stage_pick = 3'h0;
        for (int s = lo; s <= hi; s++) begin
            if (v[s]) begin
                stage_pick = 3'(s);
            end
        end
    endfunction

    // Replace enabled lanes of word w by data d
    function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] w,
                                                 input logic [DW-1:0] d,
                                                 input logic [LN-1:0] en);
        lane_merge = w;
        for (int l = 0; l < LN; l++) begin
            if (en[l]) begin
                lane_merge[l*LB +: LB] = d[l*LB +: LB];
            end
        end
    endfunction

    logic k_slot_q;
    logic [NS:0] rd_v_q;
    logic [AW-1:0] rd_a_q [0:NS];
    logic [NS:0] wr_v_q;
    logic [AW-1:0] wr_a_q [0:NS];
    logic [AW-1:0] hist_base_q [0:HN-1];
    logic [DW-1:0] hist_dat_q [0:HN-1][0:BN-1];
    logic [LN-1:0] hist_en_q [0:HN-1][0:BN-1];
    logic [DW-1:0] dq_out_q;
    logic dq_oe_q;
    logic wbuf_full_q;
    logic overrun_q;
    logic [DW-1:0] mem [0:b4s_pkg::MEM_WORDS-1];

    // Command decode, only on K edges
    wire cmd = k_slot_q & ~LOAD_STROBE_N;
    wire rd_cmd = cmd & RW_SEL;
    wire wr_cmd = cmd & ~RW_SEL;

    // Read beat fetch, one edge ahead of the bus beat
    wire [2:0] rd_stage = stage_pick(rd_v_q, b4s_pkg::RD_FIRST_STAGE,
                                     b4s_pkg::RD_LAST_STAGE);
    wire fetch = (rd_stage != 3'h0);
    wire [2:0] rd_off = rd_stage - 3'(b4s_pkg::RD_FIRST_STAGE);
    wire [AW-1:0] rd_addr = rd_a_q[rd_stage]
                            + {{(AW-2){1'b0}}, rd_off[1:0]};

    // Write beat capture
    wire [2:0] wr_stage = stage_pick(wr_v_q, b4s_pkg::WR_FIRST_STAGE,
                                     b4s_pkg::WR_LAST_STAGE);
    wire capture = (wr_stage != 3'h0);
    wire [2:0] wr_off = wr_stage - 3'(b4s_pkg::WR_FIRST_STAGE);
    wire [1:0] wr_beat = wr_off[1:0];
    wire [AW-1:0] wr_addr = wr_a_q[wr_stage]
                            + {{(AW-2){1'b0}}, wr_beat};
    wire [LN-1:0] wr_en = ~{BYTE_LANE1_WRITE_N, BYTE_LANE0_WRITE_N};
    // All lanes disabled aborts the beat entirely
    wire wr_push = capture & (wr_en != b4s_pkg::LANES_NONE);

    // Array port: reads take it, the buffer drains in the free edges
    wire f_in_ready;
    wire f_out_valid;
    wire [FW-1:0] f_out_data;
    wire drain = f_out_valid & ~fetch;
    wire [AW-1:0] dr_addr = f_out_data[FW-1 -: AW];
    wire [DW-1:0] dr_data = f_out_data[LN +: DW];
    wire [LN-1:0] dr_en = f_out_data[LN-1:0];

    b4s_wbuf_fifo #(
        .W(FW),
        .DEPTH(b4s_pkg::WBUF_DEPTH)
    ) i_b4s_wbuf_fifo (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .in_valid(wr_push),
        .in_ready(f_in_ready),
        .in_data({wr_addr, DQ_IN, wr_en}),
        .out_valid(f_out_valid),
        .out_ready(drain),
        .out_data(f_out_data)
    );

    // Coherency: newer history beats override the array, the live beat all
    wire [DW-1:0] chain [0:HN];
    assign chain[HN] = mem[rd_addr];
    genvar k;
    generate
        for (k = 0; k < HN; k++) begin : g_hist
            wire [AW-1:0] off = rd_addr - hist_base_q[k];
            wire hit = (off < AW'(BN));
            wire [LN-1:0] en = hit ? hist_en_q[k][off[1:0]]
                                   : b4s_pkg::LANES_NONE;
            assign chain[k] = lane_merge(chain[k+1],
                                         hist_dat_q[k][off[1:0]],
                                         en);
        end
    endgenerate
    wire fwd = wr_push & (wr_addr == rd_addr);
    wire [DW-1:0] rd_word = fwd ? lane_merge(chain[0], DQ_IN, wr_en)
                                : chain[0];

    always_ff @(posedge SYS_CLK) begin
        if (drain) begin
            mem[dr_addr] <= lane_merge(mem[dr_addr], dr_data, dr_en);
        end
    end

    // Slot phase and command pipelines
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            k_slot_q <= b4s_pkg::K_SLOT_RST;
            rd_v_q <= '0;
            wr_v_q <= '0;
        end else begin
            k_slot_q <= ~k_slot_q;
            rd_v_q <= {rd_v_q[NS-1:1], rd_cmd, 1'b0};
            wr_v_q <= {wr_v_q[NS-1:1], wr_cmd, 1'b0};
        end
    end

    // Start address travels with its command
    always_ff @(posedge SYS_CLK) begin
        rd_a_q[0] <= '0;
        wr_a_q[0] <= '0;
        rd_a_q[1] <= rd_cmd ? ADDR : rd_a_q[0];
        wr_a_q[1] <= wr_cmd ? ADDR : wr_a_q[0];
        for (int s = 2; s <= NS; s++) begin
            rd_a_q[s] <= rd_a_q[s-1];
            wr_a_q[s] <= wr_a_q[s-1];
        end
    end

    // History of the last two write bursts
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            for (int h = 0; h < HN; h++) begin
                for (int b = 0; b < BN; b++) begin
                    hist_en_q[h][b] <= b4s_pkg::LANES_NONE;
                end
            end
        end else if (capture && wr_beat == 2'h0) begin
            hist_en_q[1] <= hist_en_q[0];
            for (int b = 0; b < BN; b++) begin
                hist_en_q[0][b] <= (b == 0) ? wr_en
                                            : b4s_pkg::LANES_NONE;
            end
        end else if (capture) begin
            hist_en_q[0][wr_beat] <= wr_en;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (capture && wr_beat == 2'h0) begin
            hist_base_q[1] <= hist_base_q[0];
            hist_dat_q[1] <= hist_dat_q[0];
            hist_base_q[0] <= wr_addr;
            hist_dat_q[0][0] <= DQ_IN;
        end else if (capture) begin
            hist_dat_q[0][wr_beat] <= DQ_IN;
        end
    end

    // Data pins hold their value while nothing new is fetched, so a
    // stopped clock leaves them in their previous state
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            dq_out_q <= b4s_pkg::DQ_OUT_RST;
            dq_oe_q <= 1'b0;
        end else begin
            if (fetch) begin
                dq_out_q <= rd_word;
            end
            dq_oe_q <= fetch;
        end
    end

    // Lost write beats are flagged until reset; no way to stall the bus
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            wbuf_full_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            wbuf_full_q <= ~f_in_ready;
            overrun_q <= overrun_q | (wr_push & ~f_in_ready);
        end
    end

    assign DQ_OUT = dq_out_q;
    assign DQ_OE = dq_oe_q;
    assign K_SLOT = k_slot_q;
    assign WBUF_FULL = wbuf_full_q;
    assign WBUF_OVERRUN = overrun_q;
endmodule

// [tb/b4s_ctrl_model.sv]
// Controller model for the command port: commands and late write data.
// Assumes callers enter its tasks one time unit after a rising edge.
`timescale 1ns/1ps
module b4s_ctrl_model (
    input wire logic clk,
    input wire logic k_slot,
    output logic load_strobe_n = 1'b1,
    output logic rw_sel = 1'b0,
    output logic [b4s_pkg::ADDR_W-1:0] addr = 20'h00000,
    output logic [1:0] lanes_n = 2'h3,
    output logic [b4s_pkg::DATA_W-1:0] dq = 18'h00000
);
    task automatic cmd(input logic rw, input logic [19:0] a);
        while (k_slot !== 1'b1) @(posedge clk) #1;
        load_strobe_n = 1'b0;
        rw_sel = rw;
        addr = a;
        @(posedge clk) #1;
        // Stale select and address must not matter once strobe is high
        load_strobe_n = 1'b1;
        rw_sel = ~rw;
        addr = ~a;
    endtask
    task automatic wr(input logic [19:0] a, input logic [3:0][17:0] d,
                      input logic [3:0][1:0] ln);
        cmd(1'b0, a);
        // Late write: beat 0 must stand at the K edge after the command
        @(posedge clk) #1;
        for (int j = 0; j < 4; j++) begin
            dq = d[j];
            lanes_n = ln[j];
            @(posedge clk) #1;
        end
        // Released bus shows no leftover value
        dq = ~dq;
        lanes_n = 2'h3;
    endtask
    task automatic noise(input int n);
        for (int j = 0; j < n; j++) begin
            load_strobe_n = k_slot;
            rw_sel = 1'b1;
            @(posedge clk) #1;
        end
        load_strobe_n = 1'b1;
    endtask
endmodule

// [tb/b4s_command_port_assertions.sv]
// Checker on the command port pins: read timing, idle bus, slot order.
// Assumes binding into b4s_command_port; sees its ports only.
`timescale 1ns/1ps
module b4s_checker (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic LOAD_STROBE_N,
    input wire logic RW_SEL,
    input wire logic [b4s_pkg::DATA_W-1:0] DQ_OUT,
    input wire logic DQ_OE,
    input wire logic K_SLOT
);
    wire cmd_edge = K_SLOT & ~LOAD_STROBE_N;
    wire rd_take = cmd_edge & RW_SEL;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    a_read_beats_window: assert property (
        rd_take |-> ##5 DQ_OE [*4]) else $error("read window wrong");
    a_oe_needs_read: assert property (
        $rose(DQ_OE) |-> $past(rd_take, 5)) else $error("bus driven unasked");
    a_burst_two_cycles: assert property (
        $fell(DQ_OE) |-> $past(DQ_OE, 4)) else $error("burst too short");
    a_nop_no_drive: assert property (
        K_SLOT && LOAD_STROBE_N |-> ##5 !$rose(DQ_OE))
        else $error("nop drove bus");
    a_off_slot_ignored: assert property (
        not (!K_SLOT && !LOAD_STROBE_N ##5 $rose(DQ_OE)))
        else $error("strobe off slot taken");
    a_write_no_drive: assert property (
        cmd_edge && !RW_SEL |-> ##5 !$rose(DQ_OE))
        else $error("write drove bus");
    a_slot_alternates: assert property (
        !K_SLOT |=> K_SLOT) else $error("slot order wrong");
    a_slot_leaves_k: assert property (
        K_SLOT |=> !K_SLOT) else $error("slot stuck on K");
    a_idle_dq_holds: assert property (
        !DQ_OE && !$past(DQ_OE) |-> $stable(DQ_OUT))
        else $error("idle data moved");
endmodule
bind b4s_command_port b4s_checker i_b4s_checker (.SYS_CLK(SYS_CLK),
    .RST_N(RST_N), .LOAD_STROBE_N(LOAD_STROBE_N), .RW_SEL(RW_SEL),
    .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .K_SLOT(K_SLOT));

// [tb/b4s_command_port_tb_top.sv]
// Self-checking bench: bursts, lane merges, idle strobes, clock stop.
// Assumes the controller model and checker are compiled before this file.
`timescale 1ns/1ps
module b4s_command_port_tb_top;
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic clk_run = 1'b1;
    logic LOAD_STROBE_N, RW_SEL, DQ_OE, K_SLOT;
    logic WBUF_FULL, WBUF_OVERRUN;
    logic [1:0] LANES_N;
    logic [19:0] ADDR;
    logic [17:0] DQ_IN, DQ_OUT;
    logic [17:0] mem [logic [19:0]];
    int fails = 0;
    int checks_done = 0;
    initial forever #50 if (clk_run) SYS_CLK = ~SYS_CLK;
    b4s_command_port i_b4s_command_port (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
        .LOAD_STROBE_N(LOAD_STROBE_N), .RW_SEL(RW_SEL), .ADDR(ADDR),
        .BYTE_LANE0_WRITE_N(LANES_N[0]), .BYTE_LANE1_WRITE_N(LANES_N[1]),
        .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .K_SLOT(K_SLOT),
        .WBUF_FULL(WBUF_FULL), .WBUF_OVERRUN(WBUF_OVERRUN));
    b4s_ctrl_model i_b4s_ctrl_model (.clk(SYS_CLK), .k_slot(K_SLOT),
        .load_strobe_n(LOAD_STROBE_N), .rw_sel(RW_SEL), .addr(ADDR),
        .lanes_n(LANES_N), .dq(DQ_IN));
    task automatic cmp_dq(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_dq({17'h00000, got}, {17'h00000, exp});
    endtask
    task automatic close_out();
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Lane bits per beat: bit 2j is lane 0, bit 2j+1 lane 1, low writes
    task automatic wr_burst(input logic [19:0] a, input logic [17:0] base,
                            input logic [7:0] ln);
        logic [3:0][17:0] d;
        logic [19:0] p;
        for (int j = 0; j < 4; j++) begin
            d[j] = base + 18'(j);
            p = a + 20'(j);
            if (!ln[2*j]) mem[p][8:0] = d[j][8:0];
            if (!ln[2*j+1]) mem[p][17:9] = d[j][17:9];
        end
        i_b4s_ctrl_model.wr(a, d, ln);
    endtask
    task automatic rd_check(input logic [19:0] a);
        i_b4s_ctrl_model.cmd(1'b1, a);
        repeat (4) @(posedge SYS_CLK) #1;
        for (int j = 0; j < 4; j++) begin
            cmp_bit(DQ_OE, 1'b1);
            cmp_dq(DQ_OUT, mem[a+20'(j)]);
            @(posedge SYS_CLK) #1;
        end
        cmp_bit(DQ_OE, 1'b0);
    endtask
    task automatic t_bursts();
        wr_burst(20'h00200, 18'h15a00, 8'h00);
        wr_burst(20'hffffe, 18'h2a5f0, 8'h00);
        wr_burst(20'h00300, 18'h01234, 8'h00);
        rd_check(20'h00200);
        rd_check(20'hffffe);
        rd_check(20'h00300);
        // Lane 0 only, abort, lane 1 only, both lanes
        wr_burst(20'h00200, 18'h3c0c0, 8'h1e);
        rd_check(20'h00200);
        // Spaced bursts never fill the buffer, so no beat may be lost
        cmp_bit(WBUF_FULL, 1'b0);
        cmp_bit(WBUF_OVERRUN, 1'b0);
    endtask
    task automatic t_nop();
        i_b4s_ctrl_model.noise(9);
        cmp_bit(DQ_OE, 1'b0);
        rd_check(20'h00300);
    endtask
    task automatic t_clock_stop();
        rd_check(20'hffffe);
        clk_run = 1'b0;
        #2000;
        cmp_dq(DQ_OUT, mem[20'h00001]);
        cmp_bit(DQ_OE, 1'b0);
        clk_run = 1'b1;
        rd_check(20'h00300);
    endtask
    initial begin
        repeat (4) @(posedge SYS_CLK);
        #1;
        RST_N = 1'b1;
        t_bursts();
        t_nop();
        t_clock_stop();
        close_out();
    end
    // Run needs about 125 cycles; allow well over ten times that
    initial begin
        #500000;
        fails++;
        close_out();
    end
endmodule
